// ### logic/clock_tree_reset_init.sv
// clock tree, cpu clock divider, wake-up hold and reset-dependent register initialisation
// Function
// - the oscillator clock comes from exactly one of four sources and feeds the cpu clock divider.
// - the cpu clock is the divider output and a machine cycle spans two cpu clock cycles.
// - the peripheral clock runs at half the cpu clock rate.
// - an internal rc oscillator provides a nominal 7.373 MHz source clock.
// - the source choice is fixed by non-volatile configuration, not by a run-time register.
// - the crystal oscillator offers low, medium and high ranges covering 20 kHz to 12 MHz.
// - after power-up every port pin stays input only until software reconfigures it.
// - the reset cause register records the last reset source and reads xx110000 after power-up.
// - after power-on reset the watchdog control register reads 111001x1.
// - the watchdog timeout flag is set by a watchdog reset, cleared by power-on, kept by others.
// - the trim register takes the factory value on power-on reset only.
// - trim and watchdog control are touched by power-on reset alone, save the timeout flag that a watchdog reset sets.
// - the divider divides by up to 510 and may be changed at any time without stopping.
// - on wake-up the cpu clock is held off 992 or 224 oscillator cycles plus at least 60 us.
`timescale 1ns/1ps
module clock_tree_reset_init #(
	parameter int WAKE_EXTRA = clock_tree_pkg::WAKE_EXTRA_CYCLES
) (
	// clock and power-on reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// non-volatile configuration and factory trim
	input  wire logic [1:0] cfg_clock_source,
	input  wire logic [1:0] cfg_xtal_range,
	input  wire logic [6:0] factory_trim,
	// external oscillator edges, one-cycle pulses
	input  wire logic       watchdog_osc_tick,
	input  wire logic       crystal_osc_tick,
	input  wire logic       external_clk_tick,
	// non power-on reset events and wake-up request
	input  wire logic       rst_external,
	input  wire logic       rst_software,
	input  wire logic       rst_watchdog,
	input  wire logic       rst_break,
	input  wire logic       rst_brownout,
	input  wire logic       wake_req,
	// register port
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	// clocks and status
	output logic            oscillator_clock,
	output logic            cpu_core_clock,
	output logic            machine_cycle,
	output logic            peripheral_clock,
	output logic            cpu_clock_hold,
	output logic            pins_input_only,
	output logic      [6:0] trim_value,
	output logic      [2:0] watchdog_prescale,
	output logic            watchdog_run,
	output logic            watchdog_clock_select,
	output logic      [1:0] xtal_gain
);
	// ======================================================================
	// state
	typedef struct packed {
		logic [15:0] rc_acc;
		logic        rc_tick;
		logic        osc_tick;
		logic [8:0]  div_cnt;
		logic        cpu_tick;
		logic        half_phase;
		logic        machine_tick;
		logic        periph_tick;
		logic        hold;
		logic [9:0]  hold_osc;
		logic [15:0] hold_extra;
		logic [7:0]  power_control;
		logic [7:0]  periph_pd;
		logic [6:0]  trim;
		logic [7:0]  watchdog_control;
		logic [5:0]  reset_cause;
		logic [7:0]  divider;
		logic        input_only;
		logic        por_load;
		logic [7:0]  rdata;
		logic [1:0]  gain;
	} state_t;

	state_t state_reg;
	state_t state_next;

	// ======================================================================
	// address decode
	function automatic logic addr_is(input logic [7:0] a, input logic [7:0] target);
		addr_is = (a == target);
	endfunction

	logic [16:0] rc_sum;
	logic        src_tick;
	logic        any_reset;
	logic [9:0]  hold_target;
	logic [8:0]  div_last;

	always_comb
	begin
		state_next = state_reg;
		// internal rc oscillator as a phase accumulator
		rc_sum = {1'b0, state_reg.rc_acc} + clock_tree_pkg::RC_STEP;
		state_next.rc_acc = rc_sum[15:0];
		state_next.rc_tick = rc_sum[16];
		// root clock picked straight from the configuration pins
		case (clock_tree_pkg::clock_source_t'(cfg_clock_source))
			clock_tree_pkg::SRC_WATCHDOG_OSC: src_tick = watchdog_osc_tick;
			clock_tree_pkg::SRC_RC_OSC:       src_tick = state_reg.rc_tick;
			clock_tree_pkg::SRC_CRYSTAL:      src_tick = crystal_osc_tick;
			default:                          src_tick = external_clk_tick;
		endcase
		state_next.osc_tick = src_tick;
		// crystal drive range
		case (clock_tree_pkg::xtal_range_t'(cfg_xtal_range))
			clock_tree_pkg::XTAL_LOW:    state_next.gain = 2'h1;
			clock_tree_pkg::XTAL_MEDIUM: state_next.gain = 2'h2;
			default:                     state_next.gain = 2'h3;
		endcase
		// divide by 2N, or by one when N is zero; compare with >= so a shrinking N never hangs
		div_last = (state_reg.divider == 8'h00) ? 9'h000 : {state_reg.divider, 1'b0} - 9'h001;
		state_next.cpu_tick = 1'b0;
		if (state_reg.osc_tick)
		begin
			if (state_reg.div_cnt >= div_last)
			begin
				state_next.div_cnt = 9'h000;
				state_next.cpu_tick = !state_reg.hold;
			end
			else
			begin
				state_next.div_cnt = state_reg.div_cnt + 9'h001;
			end
		end
		// machine cycle and peripheral clock both every second cpu clock
		state_next.machine_tick = 1'b0;
		state_next.periph_tick = 1'b0;
		if (state_reg.cpu_tick)
		begin
			state_next.half_phase = !state_reg.half_phase;
			state_next.machine_tick = state_reg.half_phase;
			state_next.periph_tick = state_reg.half_phase;
		end
		// wake-up hold: oscillator cycles first, then the fixed settling time
		hold_target = (cfg_clock_source == 2'(clock_tree_pkg::SRC_CRYSTAL)) ?
			10'(clock_tree_pkg::WAKE_XTAL_OSC_CYCLES) : 10'(clock_tree_pkg::WAKE_OTHER_OSC_CYCLES);
		if (wake_req && !state_reg.hold)
		begin
			state_next.hold = 1'b1;
			state_next.hold_osc = 10'h000;
			state_next.hold_extra = 16'h0000;
		end
		else if (state_reg.hold)
		begin
			if (state_reg.hold_osc < hold_target)
			begin
				if (state_reg.osc_tick)
					state_next.hold_osc = state_reg.hold_osc + 10'h001;
			end
			else if (state_reg.hold_extra < 16'(WAKE_EXTRA - 1))
			begin
				state_next.hold_extra = state_reg.hold_extra + 16'h0001;
			end
			else
			begin
				state_next.hold = 1'b0;
			end
		end
		// no cpu clock pulse may start in a cycle that ends inside the hold
		if (state_next.hold)
			state_next.cpu_tick = 1'b0;
		// factory trim caught in the first cycle after power-on release
		state_next.por_load = 1'b0;
		if (state_reg.por_load)
			state_next.trim = factory_trim;
		// register reads, data valid the next cycle
		state_next.rdata = 8'h00;
		if (reg_rd)
		begin
			if (addr_is(reg_addr, clock_tree_pkg::POWER_CONTROL_ADDR))
				state_next.rdata = state_reg.power_control;
			else if (addr_is(reg_addr, clock_tree_pkg::OSC_TRIM_ADDR))
				state_next.rdata = {1'b0, state_reg.trim};
			else if (addr_is(reg_addr, clock_tree_pkg::WATCHDOG_CTRL_ADDR))
				state_next.rdata = state_reg.watchdog_control;
			else if (addr_is(reg_addr, clock_tree_pkg::PERIPH_PD_ADDR))
				state_next.rdata = state_reg.periph_pd;
			else if (addr_is(reg_addr, clock_tree_pkg::RESET_CAUSE_ADDR))
				state_next.rdata = {2'b00, state_reg.reset_cause};
			else if (addr_is(reg_addr, clock_tree_pkg::CLOCK_DIVIDER_ADDR))
				state_next.rdata = state_reg.divider;
			else if (addr_is(reg_addr, clock_tree_pkg::PIN_RELEASE_ADDR))
				state_next.rdata = {7'h00, !state_reg.input_only};
			else if (addr_is(reg_addr, clock_tree_pkg::CLOCK_CONFIG_ADDR))
				state_next.rdata = {4'h0, cfg_xtal_range, cfg_clock_source};
			else
				state_next.rdata = 8'h00;
		end
		// register writes
		if (reg_wr)
		begin
			if (addr_is(reg_addr, clock_tree_pkg::POWER_CONTROL_ADDR))
				state_next.power_control = reg_wdata;
			else if (addr_is(reg_addr, clock_tree_pkg::OSC_TRIM_ADDR))
				state_next.trim = reg_wdata[6:0] & clock_tree_pkg::TRIM_WRITE_MASK[6:0];
			else if (addr_is(reg_addr, clock_tree_pkg::WATCHDOG_CTRL_ADDR))
			begin
				state_next.watchdog_control = {reg_wdata[7:5], 2'b00, reg_wdata[2], state_reg.watchdog_control[1], reg_wdata[0]};
				// timeout flag is cleared by writing zero
				if (!reg_wdata[clock_tree_pkg::WDOG_TIMEOUT_BIT])
					state_next.watchdog_control[clock_tree_pkg::WDOG_TIMEOUT_BIT] = 1'b0;
			end
			else if (addr_is(reg_addr, clock_tree_pkg::PERIPH_PD_ADDR))
				state_next.periph_pd = reg_wdata;
			else if (addr_is(reg_addr, clock_tree_pkg::RESET_CAUSE_ADDR))
				state_next.reset_cause = state_reg.reset_cause & reg_wdata[5:0];
			else if (addr_is(reg_addr, clock_tree_pkg::CLOCK_DIVIDER_ADDR))
				state_next.divider = reg_wdata;
			else if (addr_is(reg_addr, clock_tree_pkg::PIN_RELEASE_ADDR) && reg_wdata[0])
				state_next.input_only = 1'b0;
		end
		// non power-on resets: cause flags set after any software clear, trim and watchdog kept but for the timeout flag a watchdog reset sets
		any_reset = rst_external | rst_software | rst_watchdog | rst_break | rst_brownout;
		if (any_reset)
		begin
			state_next.reset_cause = {rst_brownout, 1'b0, rst_break, rst_watchdog, rst_software, rst_external};
			state_next.power_control = clock_tree_pkg::POWER_CONTROL_RST;
			state_next.periph_pd = clock_tree_pkg::PERIPH_PD_RST;
			state_next.divider = clock_tree_pkg::CLOCK_DIVIDER_RST;
			state_next.watchdog_control = state_reg.watchdog_control;
			// the factory load of the first cycle after power-on is not lost to an event
			if (!state_reg.por_load)
				state_next.trim = state_reg.trim;
			if (rst_watchdog)
				state_next.watchdog_control[clock_tree_pkg::WDOG_TIMEOUT_BIT] = 1'b1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_reg <= '0;
			state_reg.reset_cause <= clock_tree_pkg::RESET_CAUSE_POR;
			state_reg.watchdog_control <= clock_tree_pkg::WATCHDOG_CTRL_RST;
			state_reg.power_control <= clock_tree_pkg::POWER_CONTROL_RST;
			state_reg.periph_pd <= clock_tree_pkg::PERIPH_PD_RST;
			state_reg.divider <= clock_tree_pkg::CLOCK_DIVIDER_RST;
			state_reg.input_only <= 1'b1;
			state_reg.por_load <= 1'b1;
			state_reg.gain <= 2'h3;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// ======================================================================
	// outputs
	assign reg_rdata             = state_reg.rdata;
	assign oscillator_clock      = state_reg.osc_tick;
	assign cpu_core_clock        = state_reg.cpu_tick;
	assign machine_cycle         = state_reg.machine_tick;
	assign peripheral_clock      = state_reg.periph_tick;
	assign cpu_clock_hold        = state_reg.hold;
	assign pins_input_only       = state_reg.input_only;
	assign trim_value            = state_reg.trim;
	assign watchdog_prescale     = state_reg.watchdog_control[7:5];
	assign watchdog_run          = state_reg.watchdog_control[2];
	assign watchdog_clock_select = state_reg.watchdog_control[0];
	assign xtal_gain             = state_reg.gain;

	// ======================================================================
	// assertions
	a_rc_source_follow: assert property (@(posedge clk) disable iff (!rst_n)
		(cfg_clock_source == 2'h1) && $stable(cfg_clock_source) |=> oscillator_clock == $past(state_reg.rc_tick))
		else $error("oscillator clock does not follow rc source");
	a_machine_two_cpu: assert property (@(posedge clk) disable iff (!rst_n)
		machine_cycle |-> state_reg.half_phase == 1'b0)
		else $error("machine cycle not on second cpu clock");
	a_periph_half_rate: assert property (@(posedge clk) disable iff (!rst_n)
		peripheral_clock |-> $past(cpu_core_clock) && $past(state_reg.half_phase))
		else $error("peripheral clock not half the cpu clock");
	a_rc_tick_rate: assert property (@(posedge clk) disable iff (!rst_n)
		state_reg.rc_tick |=> !state_reg.rc_tick [*4])
		else $error("rc oscillator faster than nominal");
	a_pins_after_por: assert property (@(posedge clk)
		!rst_n |=> pins_input_only)
		else $error("pins not input only after power-up");
	a_cause_por_value: assert property (@(posedge clk)
		!rst_n |=> state_reg.reset_cause == 6'h30)
		else $error("reset cause wrong after power-up");
	a_watchdog_control_por_value: assert property (@(posedge clk)
		!rst_n |=> state_reg.watchdog_control == 8'hE5)
		else $error("watchdog control wrong after reset");
	a_wdog_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
		rst_watchdog |=> state_reg.watchdog_control[1])
		else $error("watchdog reset did not set timeout flag");
	a_trim_kept: assert property (@(posedge clk) disable iff (!rst_n)
		(rst_external || rst_software || rst_brownout) && !state_reg.por_load |=> $stable(trim_value))
		else $error("trim changed by a non power-on reset");
	a_watchdog_control_kept: assert property (@(posedge clk) disable iff (!rst_n)
		(rst_external || rst_software) && !rst_watchdog |=> $stable(state_reg.watchdog_control))
		else $error("watchdog control changed by a non power-on reset");
	a_hold_no_cpu: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(cpu_clock_hold) |=> !cpu_core_clock [*8])
		else $error("cpu clock ran during wake-up hold");
	a_hold_min_len: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(cpu_clock_hold) |-> $past(state_reg.hold_extra) == 16'(WAKE_EXTRA - 1))
		else $error("wake-up hold ended early");
	a_hold_blocks_cpu: assert property (@(posedge clk) disable iff (!rst_n)
		cpu_clock_hold |-> !cpu_core_clock)
		else $error("cpu clock pulse inside wake-up hold");
	a_div_count_max: assert property (@(posedge clk) disable iff (!rst_n)
		state_reg.div_cnt <= 9'h1FD)
		else $error("divider count beyond divide by 510");
	a_divider_write: assert property (@(posedge clk) disable iff (!rst_n)
		reg_wr && (reg_addr == clock_tree_pkg::CLOCK_DIVIDER_ADDR) && !any_reset
		|=> state_reg.divider == $past(reg_wdata))
		else $error("divider value not taken at once");
	a_cause_external: assert property (@(posedge clk) disable iff (!rst_n)
		rst_external |=> state_reg.reset_cause[clock_tree_pkg::CAUSE_EXT_BIT])
		else $error("external reset not recorded");
	a_cause_software: assert property (@(posedge clk) disable iff (!rst_n)
		rst_software |=> state_reg.reset_cause[clock_tree_pkg::CAUSE_SOFT_BIT])
		else $error("software reset not recorded");
	a_cause_watchdog: assert property (@(posedge clk) disable iff (!rst_n)
		rst_watchdog |=> state_reg.reset_cause[clock_tree_pkg::CAUSE_WDOG_BIT])
		else $error("watchdog reset not recorded");
	a_cause_brownout: assert property (@(posedge clk) disable iff (!rst_n)
		rst_brownout |=> state_reg.reset_cause[clock_tree_pkg::CAUSE_BROWNOUT_BIT])
		else $error("brownout reset not recorded");
	a_trim_factory: assert property (@(posedge clk) disable iff (!rst_n)
		state_reg.por_load && !reg_wr |=> trim_value == $past(factory_trim))
		else $error("factory trim not loaded after power-on");
	a_pins_release: assert property (@(posedge clk) disable iff (!rst_n)
		reg_wr && (reg_addr == clock_tree_pkg::PIN_RELEASE_ADDR) && reg_wdata[0] |=> !pins_input_only)
		else $error("pins not released by software");
	a_source_crystal: assert property (@(posedge clk) disable iff (!rst_n)
		(cfg_clock_source == 2'h2) && $stable(cfg_clock_source) |=> oscillator_clock == $past(crystal_osc_tick))
		else $error("oscillator clock does not follow crystal source");
	a_gain_low_range: assert property (@(posedge clk) disable iff (!rst_n)
		(cfg_xtal_range == 2'h0) |=> xtal_gain == 2'h1)
		else $error("crystal drive wrong for low range");
endmodule // clock_tree_reset_init

// ### include/clock_tree_pkg.sv
// constants, offsets and reset values of the clock tree and reset initialisation block
package clock_tree_pkg;
	// ======================================================================
	// register offsets
	localparam logic [7:0] POWER_CONTROL_ADDR   = 8'h87;
	localparam logic [7:0] OSC_TRIM_ADDR        = 8'h96;
	localparam logic [7:0] WATCHDOG_CTRL_ADDR   = 8'hA7;
	localparam logic [7:0] PERIPH_PD_ADDR       = 8'hB5;
	localparam logic [7:0] RESET_CAUSE_ADDR     = 8'hDF;
	localparam logic [7:0] CLOCK_DIVIDER_ADDR   = 8'hF0;
	localparam logic [7:0] PIN_RELEASE_ADDR     = 8'hF1;
	localparam logic [7:0] CLOCK_CONFIG_ADDR    = 8'hF2;
	// ======================================================================
	// reset values
	localparam logic [7:0] POWER_CONTROL_RST    = 8'h00;
	localparam logic [7:0] PERIPH_PD_RST        = 8'h00;
	localparam logic [7:0] WATCHDOG_CTRL_RST    = 8'hE5;
	localparam logic [5:0] RESET_CAUSE_POR      = 6'h30;
	localparam logic [7:0] CLOCK_DIVIDER_RST    = 8'h00;
	// ======================================================================
	// field positions
	localparam int         WDOG_TIMEOUT_BIT     = 1;
	localparam int         CAUSE_EXT_BIT        = 0;
	localparam int         CAUSE_SOFT_BIT       = 1;
	localparam int         CAUSE_WDOG_BIT       = 2;
	localparam int         CAUSE_BREAK_BIT      = 3;
	localparam int         CAUSE_POWER_ON_BIT   = 4;
	localparam int         CAUSE_BROWNOUT_BIT   = 5;
	localparam logic [7:0] TRIM_WRITE_MASK      = 8'h7F;
	// ======================================================================
	// root clock sources and crystal ranges
	typedef enum logic [1:0] {SRC_WATCHDOG_OSC, SRC_RC_OSC, SRC_CRYSTAL, SRC_EXTERNAL} clock_source_t;
	typedef enum logic [1:0] {XTAL_LOW, XTAL_MEDIUM, XTAL_HIGH, XTAL_UNUSED} xtal_range_t;
	localparam int         XTAL_MIN_KHZ         = 20;
	localparam int         XTAL_MAX_KHZ         = 12000;
	// ======================================================================
	// timing
	localparam int         CLK_KHZ              = 40000;
	localparam int         RC_NOMINAL_KHZ       = 7373;
	localparam int         RC_ACC_BITS          = 16;
	localparam logic [16:0] RC_STEP             = 17'((longint'(RC_NOMINAL_KHZ) << RC_ACC_BITS) / CLK_KHZ);
	localparam int         WAKE_XTAL_OSC_CYCLES = 992;
	localparam int         WAKE_OTHER_OSC_CYCLES = 224;
	localparam int         WAKE_EXTRA_US        = 60;
	localparam int         WAKE_EXTRA_CYCLES    = (WAKE_EXTRA_US * CLK_KHZ + 999) / 1000;
endpackage

// ### verif/clock_tree_reset_init_tb.sv
// self-checking testbench of the clock tree and reset initialisation block
`timescale 1ns/1ps
module clock_tree_reset_init_tb;
	// ======================================================================
	// stimulus, observation and bookkeeping
	logic        clk;
	logic        rst_n;
	logic        tick;
	logic [1:0]  src;
	logic [1:0]  xrange;
	logic [6:0]  ftrim;
	logic [5:0]  ev;
	logic [7:0]  reg_addr;
	logic [7:0]  reg_wdata;
	logic [7:0]  reg_rdata;
	logic [7:0]  r1;
	logic [7:0]  r2;
	logic        reg_wr;
	logic        reg_rd;
	logic        rd_seen;
	logic        osc_clk;
	logic        cpu_clk;
	logic        mcycle;
	logic        per_clk;
	logic        hold;
	logic        pins_in;
	logic [6:0]  trim_value;
	logic [1:0]  xtal_gain;
	logic [2:0]  wd_pre;
	logic        wd_run;
	logic        wd_clk;
	logic [7:0]  exp_q[$];
	int          bad_count = 0;
	int          comparisons = 0;
	int          cpu_n = 0;
	int          osc_n = 0;
	int          mc_n = 0;
	int          pc_n = 0;
	int          hold_n = 0;
	int          hold_cpu = 0;
	int          k;
	int          seed = 32'h4766c3d5;

	clock_tree_reset_init #(.WAKE_EXTRA(20)) clock_tree_reset_init_i (
		.clk(clk), .rst_n(rst_n), .cfg_clock_source(src), .cfg_xtal_range(xrange), .factory_trim(ftrim),
		.watchdog_osc_tick(tick), .crystal_osc_tick(tick), .external_clk_tick(tick),
		.rst_external(ev[0]), .rst_software(ev[1]), .rst_watchdog(ev[2]), .rst_break(ev[3]),
		.rst_brownout(ev[4]), .wake_req(ev[5]), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .oscillator_clock(osc_clk),
		.cpu_core_clock(cpu_clk), .machine_cycle(mcycle), .peripheral_clock(per_clk),
		.cpu_clock_hold(hold), .pins_input_only(pins_in), .trim_value(trim_value),
		.watchdog_prescale(wd_pre), .watchdog_run(wd_run), .watchdog_clock_select(wd_clk), .xtal_gain(xtal_gain));

	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ======================================================================
	// source oscillator edges every second cycle, pulse counters, read monitor
	always @(posedge clk)
	begin
		tick <= ~tick;
		rd_seen <= reg_rd;
		cpu_n <= cpu_n + (cpu_clk === 1'b1);
		osc_n <= osc_n + (osc_clk === 1'b1);
		mc_n <= mc_n + (mcycle === 1'b1);
		pc_n <= pc_n + (per_clk === 1'b1);
		hold_n <= hold_n + (hold === 1'b1);
		hold_cpu <= hold_cpu + (hold === 1'b1 && cpu_clk === 1'b1);
	end

	always @(negedge clk)
		if (rd_seen === 1'b1 && exp_q.size() > 0)
			check_eq(reg_rdata, exp_q.pop_front());

	task check_eq(input logic [7:0] got, input logic [7:0] want);
		comparisons++;
		if (got !== want)
		begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask

	task check_near(input int got, input int want, input int tol);
		comparisons++;
		if (got < want - tol || got > want + tol)
		begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, want);
		end
	endtask

	// ======================================================================
	// register port, events and reset
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		exp_q.push_back(e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask

	task pulse(input int n);
		@(posedge clk);
		ev <= 6'(1 << n);
		@(posedge clk);
		ev <= 6'h00;
	endtask

	task por(input logic [1:0] s, input logic [1:0] x);
		@(posedge clk);
		src <= s;
		xrange <= x;
		ftrim <= 7'($random(seed));
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		@(negedge clk);
	endtask

	// counts cpu, machine and peripheral pulses over w cycles
	task rate(input logic [7:0] n, input int w, input int want);
		int c0, m0, p0, o0, d;
		d = (n == 8'h00) ? 1 : 2 * n;
		wr(clock_tree_pkg::CLOCK_DIVIDER_ADDR, n);
		repeat (1100) @(posedge clk);
		c0 = cpu_n;
		m0 = mc_n;
		p0 = pc_n;
		o0 = osc_n;
		repeat (w) @(posedge clk);
		check_near(cpu_n - c0, want, 1);
		check_near(mc_n - m0, want / 2, 1);
		check_near(pc_n - p0, want / 2, 1);
		check_near(osc_n - o0, want * d, 2);
	endtask

	task wake(input int want);
		int h0, q0, i;
		h0 = hold_n;
		q0 = hold_cpu;
		pulse(5);
		repeat (2) @(posedge clk);
		for (i = 0; i < 5000 && hold === 1'b1; i++)
			@(posedge clk);
		repeat (2) @(posedge clk);
		check_near(hold_n - h0, want, 4);
		check_near(hold_cpu - q0, 0, 0);
	endtask

	task test_done;
		$display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		#(25ns * 40000);
		bad_count++;
		test_done;
	end

	// ======================================================================
	// main sequence
	initial
	begin
		{rst_n, tick, ev, reg_wr, reg_rd, rd_seen} = '0;
		{src, xrange, ftrim, reg_addr, reg_wdata} = '0;
		por(2'h3, 2'h0);
		check_eq({1'b0, trim_value}, {1'b0, ftrim});
		check_eq({7'h00, pins_in}, 8'h01);
		check_eq({6'h00, xtal_gain}, 8'h01);
		check_eq({wd_pre, 2'b00, wd_run, 1'b0, wd_clk}, 8'hE5);
		rd(clock_tree_pkg::RESET_CAUSE_ADDR, 8'h30);
		rd(clock_tree_pkg::WATCHDOG_CTRL_ADDR, 8'hE5);
		rd(clock_tree_pkg::POWER_CONTROL_ADDR, 8'h00);
		rd(clock_tree_pkg::PERIPH_PD_ADDR, 8'h00);
		rd(clock_tree_pkg::CLOCK_CONFIG_ADDR, 8'h03);
		rd(8'h00, 8'h00);
		r1 = 8'($random(seed));
		r2 = 8'($random(seed));
		wr(clock_tree_pkg::POWER_CONTROL_ADDR, r1);
		wr(clock_tree_pkg::PERIPH_PD_ADDR, r1);
		wr(clock_tree_pkg::OSC_TRIM_ADDR, r2);
		wr(clock_tree_pkg::WATCHDOG_CTRL_ADDR, 8'h41);
		rd(clock_tree_pkg::POWER_CONTROL_ADDR, r1);
		rd(clock_tree_pkg::WATCHDOG_CTRL_ADDR, 8'h41);
		rd(clock_tree_pkg::PERIPH_PD_ADDR, r1);
		check_eq({wd_pre, 2'b00, wd_run, 1'b0, wd_clk}, 8'h41);
		for (k = 0; k < 5; k++)
		begin
			pulse(k);
			rd(clock_tree_pkg::RESET_CAUSE_ADDR, (k == 4) ? 8'h20 : 8'(1 << k));
			rd(clock_tree_pkg::POWER_CONTROL_ADDR, 8'h00);
			rd(clock_tree_pkg::PERIPH_PD_ADDR, 8'h00);
			rd(clock_tree_pkg::OSC_TRIM_ADDR, {1'b0, r2[6:0]});
			rd(clock_tree_pkg::WATCHDOG_CTRL_ADDR, (k >= 2) ? 8'h43 : 8'h41);
		end
		wr(clock_tree_pkg::WATCHDOG_CTRL_ADDR, 8'h41);
		rd(clock_tree_pkg::WATCHDOG_CTRL_ADDR, 8'h41);
		wr(clock_tree_pkg::RESET_CAUSE_ADDR, 8'h00);
		rd(clock_tree_pkg::RESET_CAUSE_ADDR, 8'h00);
		wr(clock_tree_pkg::PIN_RELEASE_ADDR, 8'h01);
		@(negedge clk);
		check_eq({7'h00, pins_in}, 8'h00);
		rate(8'h00, 200, 100);
		rate(8'h03, 600, 50);
		rate(8'hFF, 3060, 3);
		wake(2 * 224 + 20);
		por(2'h2, 2'h1);
		check_eq({6'h00, xtal_gain}, 8'h02);
		check_eq({7'h00, pins_in}, 8'h01);
		rd(clock_tree_pkg::CLOCK_CONFIG_ADDR, 8'h06);
		rd(clock_tree_pkg::WATCHDOG_CTRL_ADDR, 8'hE5);
		rd(clock_tree_pkg::RESET_CAUSE_ADDR, 8'h30);
		rd(clock_tree_pkg::OSC_TRIM_ADDR, {1'b0, ftrim});
		wake(2 * 992 + 20);
		por(2'h1, 2'h2);
		check_eq({6'h00, xtal_gain}, 8'h03);
		rate(8'h00, 4000, 737);
		por(2'h0, 2'h3);
		check_eq({6'h00, xtal_gain}, 8'h03);
		rate(8'h00, 200, 100);
		test_done;
	end
endmodule // clock_tree_reset_init_tb
